// file: tb/acss_host_model.sv
// Host model driving the register request port of the bank
`timescale 1ns/1ps
module acss_host_model (
  // Clock
  input  wire logic           clock,
  // Register port
  output acss_pkg::acss_req_t req,
  input  wire logic [15:0]    rdata_reg,
  input  wire logic           rvalid_reg
);
  initial req = '0;

  // Released lines flip so a stale value is never mistaken for a live one
  task automatic release_bus();
    req.wr    = 1'b0;
    req.rd    = 1'b0;
    req.addr  = ~req.addr;
    req.wdata = ~req.wdata;
  endtask

  task automatic write(input logic [15:0] addr, input logic [15:0] data);
    @(posedge clock) #1;
    req.addr  = addr;
    // Reserved config bits kept clear; bit 6 left as given to probe read-back
    req.wdata = (addr == acss_pkg::OFF_CONVERTER_INPUT_CONFIG) ?
                (data & 16'h0043) : data;
    req.wr    = 1'b1;
    @(posedge clock) #1;
    release_bus();
  endtask

  task automatic read(input logic [15:0] addr, output logic [15:0] data, output logic ok);
    int i;
    ok = 1'b0;
    data = 16'h0000;
    @(posedge clock) #1;
    req.addr = addr;
    req.rd = 1'b1;
    @(posedge clock) #1;
    release_bus();
    for (i = 0; i < 4 && !ok; i++) begin
      if (rvalid_reg === 1'b1) begin
        data = rdata_reg;
        ok = 1'b1;
      end else begin
        @(posedge clock) #1;
      end
    end
  endtask
endmodule

// file: tb/adc_config_and_system_status_tb.sv
// Self-checking bench for the configuration and primary status register bank
`timescale 1ns/1ps
module adc_config_and_system_status_tb;
  logic                  clock;
  logic                  reset_n;
  acss_pkg::acss_req_t   req;
  logic [15:0]           rdata_reg;
  logic                  rvalid_reg;
  logic                  alert_response;
  logic                  power_on_cause;
  logic                  average_done;
  logic                  conversion_done;
  logic                  secondary_status_any;
  logic                  power_voltage_source;
  acss_pkg::acss_route_t alert_route;
  acss_pkg::acss_route_t sticky_route;
  logic                  drain_aux;
  logic                  supply_aux;
  logic                  supply_vout;
  logic                  report_avg;
  logic [3:0]            code;
  logic [16:0]           samples;
  logic [3:0]            a_pin;
  logic [3:0]            a_oe;
  logic [3:0]            s_pin;
  logic [3:0]            s_oe;
  int                    n_errors;
  int                    n_compared;

  acss_bank u_acss_bank (
    .clock(clock), .reset_n(reset_n), .req(req), .rdata_reg(rdata_reg),
    .rvalid_reg(rvalid_reg), .alert_response(alert_response),
    .power_on_cause(power_on_cause), .average_done(average_done),
    .conversion_done(conversion_done), .secondary_status_any(secondary_status_any),
    .power_voltage_source(power_voltage_source), .alert_route(alert_route),
    .sticky_route(sticky_route), .drain_source_aux_enable_reg(drain_aux),
    .supply_aux_enable_reg(supply_aux), .supply_aux_is_vout_reg(supply_vout),
    .report_averaged_reg(report_avg), .sample_code_reg(code),
    .samples_per_average_reg(samples), .alert_pin_reg(a_pin), .alert_pin_oe_reg(a_oe),
    .sticky_pin_reg(s_pin), .sticky_pin_oe_reg(s_oe)
  );
  acss_host_model u_acss_host_model (
    .clock(clock), .req(req), .rdata_reg(rdata_reg), .rvalid_reg(rvalid_reg)
  );

  // ************************************************************
  // Helpers
  // ************************************************************
  task automatic chk_reg(input string name, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic chk_out(input string name, input logic [16:0] exp, input logic [16:0] got);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic rd_chk(input logic [15:0] addr, input logic [15:0] exp);
    logic [15:0] d;
    logic        ok;
    u_acss_host_model.read(addr, d, ok);
    chk_out("rvalid", 17'h00001, 17'(ok));
    chk_reg($sformatf("reg %h", addr), exp, d);
  endtask

  task automatic wr(input logic [15:0] addr, input logic [15:0] data);
    u_acss_host_model.write(addr, data);
  endtask

  // Event 0 average, 1 conversion, other alert response
  task automatic pulse(input int which);
    @(posedge clock) #1;
    case (which)
      0: average_done = 1'b1;
      1: conversion_done = 1'b1;
      default: alert_response = 1'b1;
    endcase
    @(posedge clock) #1;
    average_done = 1'b0;
    conversion_done = 1'b0;
    alert_response = 1'b0;
    repeat (3) @(posedge clock);
  endtask

  task automatic do_reset(input logic cause);
    reset_n = 1'b0;
    power_on_cause = cause;
    repeat (20) @(posedge clock);
    #1 reset_n = 1'b1;
    repeat (5) @(posedge clock);
  endtask

  task automatic test_done();
    $display("Compared %0d, mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // ************************************************************
  // Stimulus
  // ************************************************************
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  initial begin
    #400000;
    n_errors++;
    $display("[ERR] watchdog expected finish seen timeout");
    test_done();
  end

  initial begin
    n_errors = 0;
    n_compared = 0;
    reset_n = 1'b0;
    {alert_response, average_done, conversion_done, secondary_status_any} = 4'h0;
    power_on_cause = 1'b1;
    power_voltage_source = 1'b1;
    alert_route = '{select: 2'h2, active_low: 1'b0};
    sticky_route = '{select: 2'h1, active_low: 1'b1};
    do_reset(1'b1);
    rd_chk(acss_pkg::OFF_CONVERTER_INPUT_CONFIG, 16'h0001);
    rd_chk(acss_pkg::OFF_AVERAGING_SELECT, 16'h0085);
    rd_chk(acss_pkg::OFF_PRIMARY_STATUS_ALERT_MASK, 16'h3cfe);
    rd_chk(acss_pkg::OFF_PRIMARY_STATUS_WORD, 16'h0c00);
    rd_chk(16'h1234, 16'h0000);
    chk_out("drain_aux", 17'h00000, 17'(drain_aux));
    chk_out("supply_vout", 17'h00001, 17'(supply_aux & supply_vout));
    chk_out("report_avg", 17'h00001, 17'(report_avg));
    chk_out("samples", 17'h00040, samples);
    $display("Test reset values done");

    wr(acss_pkg::OFF_CONVERTER_INPUT_CONFIG, 16'h00ff);
    rd_chk(acss_pkg::OFF_CONVERTER_INPUT_CONFIG, 16'h0003);
    chk_out("drain_aux", 17'h00001, 17'(drain_aux));
    power_voltage_source = 1'b0;
    repeat (3) @(posedge clock);
    #1;
    chk_out("supply_vout", 17'h00000, 17'(supply_vout));
    wr(acss_pkg::OFF_CONVERTER_INPUT_CONFIG, 16'h0002);
    rd_chk(acss_pkg::OFF_CONVERTER_INPUT_CONFIG, 16'h0002);
    chk_out("supply_aux", 17'h00000, 17'(supply_aux));
    $display("Test converter config done");

    for (int c = 0; c < 16; c++) begin
      wr(acss_pkg::OFF_AVERAGING_SELECT, 16'h00f0 | 16'(c));
      rd_chk(acss_pkg::OFF_AVERAGING_SELECT, 16'h0080 | 16'(c));
      chk_out("samples", 17'h00001 << (c + 1), samples);
      chk_out("code", 17'(c), 17'(code));
    end
    wr(acss_pkg::OFF_AVERAGING_SELECT, 16'h0005);
    rd_chk(acss_pkg::OFF_AVERAGING_SELECT, 16'h0005);
    chk_out("report_avg", 17'h00000, 17'(report_avg));
    $display("Test averaging done");

    wr(acss_pkg::OFF_PRIMARY_STATUS_ALERT_MASK, 16'hffff);
    rd_chk(acss_pkg::OFF_PRIMARY_STATUS_ALERT_MASK, 16'h3cfe);
    wr(acss_pkg::OFF_PRIMARY_STATUS_WORD, 16'hffff);
    rd_chk(acss_pkg::OFF_PRIMARY_STATUS_WORD, 16'h0000);
    wr(acss_pkg::OFF_PRIMARY_STATUS_ALERT_MASK, 16'h0000);
    pulse(0);
    rd_chk(acss_pkg::OFF_PRIMARY_STATUS_WORD, 16'hc080);
    chk_out("alert_pin", 17'h00044, 17'({a_oe, a_pin}));
    chk_out("sticky_pin", 17'h00020, 17'({s_oe, s_pin}));
    pulse(2);
    rd_chk(acss_pkg::OFF_PRIMARY_STATUS_WORD, 16'h4080);
    chk_out("alert_pin", 17'h00000, 17'(a_pin));
    wr(acss_pkg::OFF_PRIMARY_STATUS_WORD, 16'h4080);
    rd_chk(acss_pkg::OFF_PRIMARY_STATUS_WORD, 16'h0000);
    chk_out("sticky_pin", 17'h00002, 17'(s_pin));
    $display("Test alert flow done");

    wr(acss_pkg::OFF_PRIMARY_STATUS_ALERT_MASK, 16'h0040);
    pulse(1);
    rd_chk(acss_pkg::OFF_PRIMARY_STATUS_WORD, 16'h0040);
    secondary_status_any = 1'b1;
    wr(acss_pkg::OFF_PRIMARY_STATUS_WORD, 16'h0001);
    rd_chk(acss_pkg::OFF_PRIMARY_STATUS_WORD, 16'hc041);
    secondary_status_any = 1'b0;
    wr(acss_pkg::OFF_PRIMARY_STATUS_WORD, 16'hffff);
    rd_chk(acss_pkg::OFF_PRIMARY_STATUS_WORD, 16'h0000);
    $display("Test masked and summary done");

    wr(acss_pkg::OFF_PRIMARY_STATUS_ALERT_MASK, 16'h3cfe);
    wr(acss_pkg::OFF_PRIMARY_STATUS_SET, 16'hffff);
    rd_chk(acss_pkg::OFF_PRIMARY_STATUS_SET, 16'hccc1);
    $display("Test set register done");

    do_reset(1'b0);
    rd_chk(acss_pkg::OFF_PRIMARY_STATUS_WORD, 16'h0400);
    rd_chk(acss_pkg::OFF_CONVERTER_INPUT_CONFIG, 16'h0001);
    $display("Test reboot reset done");
    test_done();
  end
endmodule

// file: verilog/acss_bank.sv
// Converter configuration, averaging and primary status register bank
`timescale 1ns/1ps
module acss_bank (
  // Clock and reset
  input  wire logic                             clock,
  input  wire logic                             reset_n,
  // Register access
  input  wire acss_pkg::acss_req_t              req,
  output logic [15:0]                           rdata_reg,
  output logic                                  rvalid_reg,
  // Events and levels from the measurement side
  input  wire logic                             alert_response,
  input  wire logic                             power_on_cause,
  input  wire logic                             average_done,
  input  wire logic                             conversion_done,
  input  wire logic                             secondary_status_any,
  input  wire logic                             power_voltage_source,
  // Pin routing configuration
  input  wire acss_pkg::acss_route_t            alert_route,
  input  wire acss_pkg::acss_route_t            sticky_route,
  // Converter steering
  output logic                                  drain_source_aux_enable_reg,
  output logic                                  supply_aux_enable_reg,
  output logic                                  supply_aux_is_vout_reg,
  output logic                                  report_averaged_reg,
  output logic [3:0]                            sample_code_reg,
  output logic [16:0]                           samples_per_average_reg,
  // Status pins
  output logic [acss_pkg::PIN_COUNT-1:0]        alert_pin_reg,
  output logic [acss_pkg::PIN_COUNT-1:0]        alert_pin_oe_reg,
  output logic [acss_pkg::PIN_COUNT-1:0]        sticky_pin_reg,
  output logic [acss_pkg::PIN_COUNT-1:0]        sticky_pin_oe_reg
);

  // ************************************************************
  // Reset release
  // ************************************************************
  logic        rst_meta_reg;
  logic        rst_n_reg;
  logic        started_reg;
  logic        start_pulse;

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta_reg <= 1'b0;
      rst_n_reg    <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n_reg    <= rst_meta_reg;
    end
  end

  always_ff @(posedge clock or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      started_reg <= 1'b0;
    end else begin
      started_reg <= 1'b1;
    end
  end

  assign start_pulse = rst_n_reg & ~started_reg;

  // ************************************************************
  // Decode
  // ************************************************************
  logic        wr_cfg;
  logic        wr_avg;
  logic        wr_status;
  logic        wr_set;
  logic        wr_mask;

  assign wr_cfg    = req.wr & (req.addr == acss_pkg::OFF_CONVERTER_INPUT_CONFIG);
  assign wr_avg    = req.wr & (req.addr == acss_pkg::OFF_AVERAGING_SELECT);
  assign wr_status = req.wr & (req.addr == acss_pkg::OFF_PRIMARY_STATUS_WORD);
  assign wr_set    = req.wr & (req.addr == acss_pkg::OFF_PRIMARY_STATUS_SET);
  assign wr_mask   = req.wr & (req.addr == acss_pkg::OFF_PRIMARY_STATUS_ALERT_MASK);

  // ************************************************************
  // Configuration registers
  // ************************************************************
  logic [7:0]  cfg_reg;
  logic [7:0]  avg_reg;
  logic [15:0] mask_reg;

  // Reserved config bits 7 and 5:2 kept as written; host keeps them zero
  always_ff @(posedge clock or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      cfg_reg <= acss_pkg::CFG_RESET;
    end else if (wr_cfg) begin
      cfg_reg <= req.wdata[7:0] & acss_pkg::CFG_WR_MASK;
    end
  end

  always_ff @(posedge clock or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      avg_reg <= acss_pkg::AVG_RESET;
    end else if (wr_avg) begin
      avg_reg <= req.wdata[7:0] & acss_pkg::AVG_WR_MASK;
    end
  end

  always_ff @(posedge clock or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      mask_reg <= acss_pkg::MASK_RESET;
    end else if (wr_mask) begin
      mask_reg <= req.wdata & acss_pkg::MASK_WR_MASK;
    end
  end

  // ************************************************************
  // Converter steering outputs
  // ************************************************************
  always_ff @(posedge clock or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      drain_source_aux_enable_reg <= 1'b0;
      supply_aux_enable_reg       <= 1'b0;
      supply_aux_is_vout_reg      <= 1'b0;
      report_averaged_reg         <= 1'b0;
      sample_code_reg             <= 4'h0;
      samples_per_average_reg     <= 17'h00000;
    end else begin
      drain_source_aux_enable_reg <= cfg_reg[acss_pkg::CFG_DRAIN_SOURCE_BIT];
      supply_aux_enable_reg       <= cfg_reg[acss_pkg::CFG_SUPPLY_BIT];
      // Power path on input leaves the output supply free for the auxiliary slot
      supply_aux_is_vout_reg      <= power_voltage_source;
      report_averaged_reg         <= avg_reg[acss_pkg::AVG_REPORT_BIT];
      sample_code_reg             <= avg_reg[acss_pkg::AVG_CODE_MSB:0];
      samples_per_average_reg     <= 17'h00002 << avg_reg[acss_pkg::AVG_CODE_MSB:0];
    end
  end

  // ************************************************************
  // Primary status word
  // ************************************************************
  logic [15:0] status_reg;
  logic [15:0] hw_set;
  logic [15:0] sw_set;
  logic [15:0] sw_clr;
  logic [15:0] alert_clr;
  logic [15:0] rising;
  logic        alert_event;

  always_comb begin
    hw_set = 16'h0000;
    hw_set[acss_pkg::ST_POWER_LOSS_BIT]   = start_pulse & power_on_cause;
    hw_set[acss_pkg::ST_RESET_DONE_BIT]   = start_pulse;
    hw_set[acss_pkg::ST_AVERAGE_DONE_BIT] = average_done;
    hw_set[acss_pkg::ST_CONV_DONE_BIT]    = conversion_done;
    hw_set[acss_pkg::ST_SUMMARY_BIT]      = secondary_status_any;
    hw_set[acss_pkg::ST_ALERT_BIT]        = alert_event;
    hw_set[acss_pkg::ST_STICKY_BIT]       = alert_event;
  end

  assign sw_set = wr_set ? (req.wdata & acss_pkg::STATUS_IMPL) : 16'h0000;
  assign sw_clr = wr_status ? req.wdata : 16'h0000;
  // Alert response touches only the alert bit, never the sticky copy
  assign alert_clr = alert_response ? (16'h0001 << acss_pkg::ST_ALERT_BIT) : 16'h0000;

  // Unmasked sources that go from clear to set raise one alert
  assign rising = (hw_set | sw_set) & ~status_reg & ~mask_reg & acss_pkg::ALERT_SOURCES;

  always_ff @(posedge clock or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      alert_event <= 1'b0;
    end else begin
      alert_event <= |rising;
    end
  end

  // Set wins over clear so no event is lost in the clearing cycle
  always_ff @(posedge clock or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      status_reg <= acss_pkg::STATUS_RESET;
    end else begin
      status_reg <= ((status_reg & ~sw_clr & ~alert_clr) | hw_set | sw_set)
                    & acss_pkg::STATUS_IMPL;
    end
  end

  // ************************************************************
  // Read path
  // ************************************************************
  logic [15:0] rd_mux;

  always_comb begin
    rd_mux = 16'h0000;
    unique case (req.addr)
      acss_pkg::OFF_CONVERTER_INPUT_CONFIG: begin
        rd_mux = {8'h00, cfg_reg};
      end
      acss_pkg::OFF_AVERAGING_SELECT: begin
        rd_mux = {8'h00, avg_reg};
      end
      acss_pkg::OFF_PRIMARY_STATUS_WORD,
      acss_pkg::OFF_PRIMARY_STATUS_SET: begin
        rd_mux = status_reg;
      end
      acss_pkg::OFF_PRIMARY_STATUS_ALERT_MASK: begin
        rd_mux = mask_reg;
      end
      default: begin
        rd_mux = 16'h0000;
      end
    endcase
  end

  always_ff @(posedge clock or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      rdata_reg  <= 16'h0000;
      rvalid_reg <= 1'b0;
    end else begin
      rvalid_reg <= req.rd;
      rdata_reg  <= req.rd ? rd_mux : 16'h0000;
    end
  end

  // ************************************************************
  // Pin routing
  // ************************************************************
  acss_pin_route u_alert_route (
    .clock       (clock),
    .rst_n       (rst_n_reg),
    .level       (status_reg[acss_pkg::ST_ALERT_BIT]),
    .route       (alert_route),
    .pin_out_reg (alert_pin_reg),
    .pin_oe_reg  (alert_pin_oe_reg)
  );

  acss_pin_route u_sticky_route (
    .clock       (clock),
    .rst_n       (rst_n_reg),
    .level       (status_reg[acss_pkg::ST_STICKY_BIT]),
    .route       (sticky_route),
    .pin_out_reg (sticky_pin_reg),
    .pin_oe_reg  (sticky_pin_oe_reg)
  );

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n_reg);

  sequence s_unmasked_average;
    average_done && !mask_reg[7] && !status_reg[7];
  endsequence

  sequence s_alert_raised;
    ##2 (status_reg[15] && status_reg[14]);
  endsequence

  a_cfg_bit6_zero: assert property (
    req.rd && req.addr == 16'h00d8 |=> rvalid_reg && !rdata_reg[6])
    else $error("config bit 6 read as one");

  a_ds_follows_write: assert property (
    wr_cfg |-> ##2 drain_source_aux_enable_reg == $past(req.wdata[1], 2))
    else $error("drain-source enable does not follow write");

  a_supply_follows: assert property (
    wr_cfg |-> ##2 supply_aux_enable_reg == $past(req.wdata[0], 2))
    else $error("supply enable does not follow write");

  a_report_follows: assert property (
    wr_avg |-> ##2 report_averaged_reg == $past(req.wdata[7], 2))
    else $error("averaged report flag does not follow write");

  a_sample_count: assert property (
    started_reg |-> samples_per_average_reg == (17'h00002 << $past(avg_reg[3:0]))
                    && sample_code_reg == $past(avg_reg[3:0]))
    else $error("samples per average mismatch");

  a_alert_raise: assert property (
    s_unmasked_average |-> s_alert_raised)
    else $error("unmasked event raised no alert");

  a_alert_response: assert property (
    alert_response && !alert_event && !(wr_set && req.wdata[15]) |=> !status_reg[15])
    else $error("alert response did not clear alert");

  a_sticky_holds: assert property (
    status_reg[14] && alert_response && !(wr_status && req.wdata[14]) |=> status_reg[14])
    else $error("sticky alert cleared by response");

  a_average_done: assert property (
    average_done |=> status_reg[7])
    else $error("average done not latched");

  a_conv_done: assert property (
    conversion_done |=> status_reg[6])
    else $error("conversion done not latched");

  a_summary_set: assert property (
    secondary_status_any |=> status_reg[0])
    else $error("secondary summary not set");

  a_reset_done: assert property (
    start_pulse |=> status_reg[10] && status_reg[11] == $past(power_on_cause))
    else $error("reset flags wrong after release");

  a_w1c_clear: assert property (
    wr_status && req.wdata[7] && !average_done && !wr_set |=> !status_reg[7])
    else $error("write one did not clear status bit");

  a_mask_ro_zero: assert property (
    mask_reg[15:14] == 2'b00 && mask_reg[9:8] == 2'b00 && !mask_reg[0])
    else $error("read-only mask bit set");

  a_reserved_zero: assert property (
    status_reg[13:12] == 2'b00 && status_reg[9:8] == 2'b00 && status_reg[5:1] == 5'h00)
    else $error("reserved status bit set");

endmodule

// file: verilog/acss_pin_route.sv
// Routes one status level to a chosen pin with chosen polarity
`timescale 1ns/1ps
module acss_pin_route (
  // Clock and reset
  input  wire logic                             clock,
  input  wire logic                             rst_n,
  // Source and configuration
  input  wire logic                             level,
  input  wire acss_pkg::acss_route_t            route,
  // Pins
  output logic [acss_pkg::PIN_COUNT-1:0]        pin_out_reg,
  output logic [acss_pkg::PIN_COUNT-1:0]        pin_oe_reg
);

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pin_out_reg <= '0;
      pin_oe_reg  <= '0;
    end else begin
      for (int i = 0; i < acss_pkg::PIN_COUNT; i++) begin
        pin_oe_reg[i]  <= (route.select == i[acss_pkg::PIN_SEL_W-1:0]);
        pin_out_reg[i] <= (route.select == i[acss_pkg::PIN_SEL_W-1:0]) &
                          (level ^ route.active_low);
      end
    end
  end

endmodule

// file: verilog/acss_pkg.sv
// Package for the converter configuration and primary status register bank
package acss_pkg;

  // ************************************************************
  // Register offsets
  // ************************************************************
  localparam logic [15:0] OFF_CONVERTER_INPUT_CONFIG    = 16'h00d8;
  localparam logic [15:0] OFF_AVERAGING_SELECT          = 16'h00d9;
  localparam logic [15:0] OFF_PRIMARY_STATUS_WORD       = 16'h00e0;
  localparam logic [15:0] OFF_PRIMARY_STATUS_SET        = 16'hfeca;
  localparam logic [15:0] OFF_PRIMARY_STATUS_ALERT_MASK = 16'hfeda;

  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int CFG_DRAIN_SOURCE_BIT = 1;
  localparam int CFG_SUPPLY_BIT       = 0;
  localparam int CFG_ZERO_BIT         = 6;
  localparam int AVG_REPORT_BIT       = 7;
  localparam int AVG_CODE_MSB         = 3;
  localparam int ST_ALERT_BIT         = 15;
  localparam int ST_STICKY_BIT        = 14;
  localparam int ST_POWER_LOSS_BIT    = 11;
  localparam int ST_RESET_DONE_BIT    = 10;
  localparam int ST_AVERAGE_DONE_BIT  = 7;
  localparam int ST_CONV_DONE_BIT     = 6;
  localparam int ST_SUMMARY_BIT       = 0;

  // ************************************************************
  // Reset values and bit masks
  // ************************************************************
  localparam logic [7:0]  CFG_RESET      = 8'h01;
  localparam logic [7:0]  CFG_WR_MASK    = 8'hbf;
  localparam logic [7:0]  AVG_RESET      = 8'h85;
  localparam logic [7:0]  AVG_WR_MASK    = 8'h8f;
  localparam logic [15:0] STATUS_RESET   = 16'h0000;
  localparam logic [15:0] STATUS_IMPL    = 16'hccc1;
  localparam logic [15:0] MASK_RESET     = 16'h3cfe;
  localparam logic [15:0] MASK_WR_MASK   = 16'h3cfe;
  localparam logic [15:0] ALERT_SOURCES  = 16'h0cc1;

  // ************************************************************
  // Pin routing
  // ************************************************************
  localparam int PIN_COUNT = 4;
  localparam int PIN_SEL_W = 2;

  // ************************************************************
  // Carriers
  // ************************************************************
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [15:0] addr;
    logic [15:0] wdata;
  } acss_req_t;

  typedef struct packed {
    logic [PIN_SEL_W-1:0] select;
    logic                 active_low;
  } acss_route_t;

endpackage
